// >>> design/serial_port_pkg.sv
/*
  Shared constants for the serial peripheral port: word widths, bit
  positions, prescale structure, reset values and the master clock state.
  Assumes nothing of its surroundings; imported whole by every module except link_peer.
*/
package serial_port_pkg;

  // ----------------------------------------------------------------
  // word geometry
  // ----------------------------------------------------------------
  localparam int          SHIFT_WIDTH  = 16;
  localparam logic [4:0]  BYTE_BITS    = 5'h08;
  localparam logic [4:0]  WORD_BITS    = 5'h10;
  localparam int          BYTE_MSB     = 7;
  localparam int          WORD_MSB     = 15;
  localparam int          IN_BIT       = 0;
  localparam logic [15:0] SHIFT_RESET  = 16'h0000;
  localparam logic [15:0] BUFFER_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 100;
  localparam logic [1:0]  QUARTER_LAST  = 2'h3;
  localparam int          PRI_WIDTH     = 2;
  localparam int          SEC_WIDTH     = 3;
  localparam int          SYNC_STAGES   = 2;

  // ----------------------------------------------------------------
  // master clock generator state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_IDLE = 2'b01,
    CLK_RUN  = 2'b10
  } clk_state_t;

endpackage

// >>> design/input_sync.sv
/*
  Two-flop synchroniser for pin inputs.
  Assumes asynchronous levels in; only the second stage is read outside.
*/
`timescale 1ns/100ps
`default_nettype none
module input_sync
  import serial_port_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds the second only, to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stage1 <= '0;
      q_o    <= '0;
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end

endmodule
`default_nettype wire

// >>> design/port_clock_divider.sv
/*
  Shift clock prescaler: a fixed quarter divider, then a primary and a
  secondary programmable stage. Each tick is one half period of the
  serial clock. Assumes the prescale fields are stable while run_i is high.
*/
`timescale 1ns/100ps
`default_nettype none
module port_clock_divider
  import serial_port_pkg::*;
#(
  parameter int PRI_W = PRI_WIDTH,
  parameter int SEC_W = SEC_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             run_i,
  input  wire logic [PRI_W-1:0] primary_prescale_i,
  input  wire logic [SEC_W-1:0] secondary_prescale_i,
  output logic                  tick_o
);

  logic [1:0]       quarter_cnt;
  logic [PRI_W-1:0] pri_cnt;
  logic [SEC_W-1:0] sec_cnt;

  // ----------------------------------------------------------------
  // stage enables, each field divides by its value plus one
  // ----------------------------------------------------------------
  wire quarter_en = run_i && (quarter_cnt == QUARTER_LAST);
  wire pri_en     = quarter_en && (pri_cnt == primary_prescale_i);
  assign tick_o   = pri_en && (sec_cnt == secondary_prescale_i);

  // counters rest at zero so the first half period is always full length
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !run_i) begin
      quarter_cnt <= '0;
      pri_cnt     <= '0;
      sec_cnt     <= '0;
    end else begin
      quarter_cnt <= quarter_cnt + 2'h1;
      if (quarter_en) pri_cnt <= pri_en ? '0 : pri_cnt + 1'b1;
      if (pri_en)     sec_cnt <= tick_o ? '0 : sec_cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> design/serial_peripheral_port.sv
/*
  Serial peripheral port: 16-bit shift register, double-buffered transmit
  and receive behind one buffer port, master or slave shift clock.
  Assumes a 10 MHz clk_i, control inputs held steady during a transfer,
  and buffer strobes that are single-cycle pulses from same-clock logic.

*/
`timescale 1ns/100ps
`default_nettype none
module serial_peripheral_port
  import serial_port_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // control
  input  wire logic                 port_enable_i,
  input  wire logic                 master_mode_i,
  input  wire logic                 word_width_select_i,
  input  wire logic                 clock_idle_polarity_i,
  input  wire logic                 clock_edge_select_i,
  input  wire logic                 slave_select_enable_i,
  input  wire logic [PRI_WIDTH-1:0] primary_prescale_i,
  input  wire logic [SEC_WIDTH-1:0] secondary_prescale_i,
  input  wire logic                 irq_enable_i,
  input  wire logic                 irq_clear_i,
  // buffer port
  input  wire logic                 buf_write_i,
  input  wire logic [15:0]          buf_wdata_i,
  input  wire logic                 buf_read_i,
  output logic [15:0]               buf_rdata_o,
  // status
  output logic                      rx_full_o,
  output logic                      tx_full_o,
  output logic                      rx_overrun_flag_o,
  output logic                      irq_flag_o,
  output logic                      irq_o,
  // pins
  input  wire logic                 serial_data_in_i,
  output logic                      serial_data_out_o,
  output logic                      serial_data_out_oe_o,
  input  wire logic                 shift_clock_pin_i,
  output logic                      shift_clock_pin_o,
  output logic                      shift_clock_pin_oe_o,
  input  wire logic                 slave_select_n_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  clk_state_t  state;
  logic        sck_level;
  logic [4:0]  half_cnt;
  logic [4:0]  bit_cnt;
  logic        slave_busy;
  logic [15:0] shift_reg;
  logic [15:0] cur_word;
  logic [15:0] tx_buf;
  logic [15:0] rx_buf;
  logic        sdo_q;
  logic        sck_prev;
  logic        ss_prev;
  logic        width_prev;
  logic        sdi_s;
  logic        sck_s;
  logic        ss_n_s;
  logic        m_tick;

  // ----------------------------------------------------------------
  // pin synchronisers and master clock prescaler
  // ----------------------------------------------------------------
  input_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({serial_data_in_i, shift_clock_pin_i, slave_select_n_i}),
    .q_o       ({sdi_s, sck_s, ss_n_s})
  );

  // overrun stops the prescaler and clears its counters so the master clock pauses cleanly
  port_clock_divider #(
    .PRI_W (PRI_WIDTH),
    .SEC_W (SEC_WIDTH)
  ) u_div (
    .clk_i                (clk_i),
    .reset_n_i            (reset_n_i),
    .run_i                ((state == CLK_RUN) && !rx_overrun_flag_o),
    .primary_prescale_i   (primary_prescale_i),
    .secondary_prescale_i (secondary_prescale_i),
    .tick_o               (m_tick)
  );

  // ----------------------------------------------------------------
  // word geometry
  // ----------------------------------------------------------------
  function automatic logic out_bit(input logic [15:0] w, input logic wide);
    out_bit = wide ? w[WORD_MSB] : w[BYTE_MSB];
  endfunction

  wire [4:0]  nbits    = word_width_select_i ? WORD_BITS : BYTE_BITS;
  wire [5:0]  half_end = {1'b0, nbits} + {1'b0, nbits} - 6'h01;
  wire [15:0] rx_raw   = {shift_reg[15:1], sdi_s};
  wire [15:0] rx_word  = word_width_select_i ? rx_raw : {8'h00, rx_raw[7:0]};

  // ----------------------------------------------------------------
  // edge sources: own prescaled clock or the external one
  // ----------------------------------------------------------------
  wire m_run     = (state == CLK_RUN) && m_tick;
  wire m_lead    = m_run && (sck_level == clock_idle_polarity_i);
  wire m_trail   = m_run && (sck_level != clock_idle_polarity_i);
  wire sel_ok    = !slave_select_enable_i || !ss_n_s;
  wire s_edge    = (sck_s != sck_prev) && sel_ok;
  wire s_lead    = s_edge && (sck_prev == clock_idle_polarity_i);
  wire s_trail   = s_edge && (sck_prev != clock_idle_polarity_i);
  wire live      = port_enable_i && !rx_overrun_flag_o;
  wire lead_ev   = live && (master_mode_i ? m_lead : s_lead);
  wire trail_ev  = live && (master_mode_i ? m_trail : s_trail);

  // edge select: set means data changes on the active-to-idle edge
  wire sample_ev = clock_edge_select_i ? lead_ev : trail_ev;
  wire change_ev = clock_edge_select_i ? trail_ev : lead_ev;
  wire shift_ok  = change_ev && (!clock_edge_select_i || bit_cnt != 5'h00);
  wire complete  = sample_ev && (bit_cnt == nbits - 5'h01);

  // ----------------------------------------------------------------
  // load and restart conditions
  // ----------------------------------------------------------------
  wire busy      = master_mode_i ? (state == CLK_RUN) : slave_busy;
  wire load_go   = port_enable_i && tx_full_o && !busy && !rx_overrun_flag_o;
  wire ss_rise   = slave_select_enable_i && !master_mode_i && ss_n_s && !ss_prev;
  wire restart   = !port_enable_i || ss_rise || (width_prev != word_width_select_i);
  wire rx_room   = !rx_full_o || buf_read_i;

  // edge detector history: clock and select from the second sync stage, width straight from its input
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sck_prev   <= 1'b0;
      ss_prev    <= 1'b1;
      width_prev <= 1'b0;
    end else begin
      sck_prev   <= sck_s;
      ss_prev    <= ss_n_s;
      width_prev <= word_width_select_i;
    end
  end

  // ----------------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------------
  // one tick per half period, 2N halves, idle level restored at the end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state     <= CLK_IDLE;
      sck_level <= 1'b0;
      half_cnt  <= 5'h00;
    end else if (restart || !master_mode_i) begin
      state     <= CLK_IDLE;
      sck_level <= clock_idle_polarity_i;
      half_cnt  <= 5'h00;
    end else begin
      case (state)
        CLK_IDLE: begin
          sck_level <= clock_idle_polarity_i;
          half_cnt  <= 5'h00;
          if (load_go) state <= CLK_RUN;
        end
        CLK_RUN: begin
          if (m_tick && !rx_overrun_flag_o) begin
            sck_level <= !sck_level;
            half_cnt  <= half_cnt + 5'h01;
            if ({1'b0, half_cnt} == half_end) begin
              state     <= CLK_IDLE;
              sck_level <= clock_idle_polarity_i;
            end
          end
        end
        default: begin
          state <= CLK_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift register, bit counter, data output
  // ----------------------------------------------------------------
  // sample edge fills bit 0, change edge presents the msb and shifts
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shift_reg  <= SHIFT_RESET;
      cur_word   <= SHIFT_RESET;
      sdo_q      <= 1'b0;
      bit_cnt    <= 5'h00;
      slave_busy <= 1'b0;
    end else if (restart) begin
      // reload the current word so the next select starts at the msb
      bit_cnt    <= 5'h00;
      slave_busy <= 1'b0;
      shift_reg  <= clock_edge_select_i ? {cur_word[14:0], 1'b0} : cur_word;
      if (clock_edge_select_i) sdo_q <= out_bit(cur_word, word_width_select_i);
    end else if (load_go) begin
      cur_word   <= tx_buf;
      shift_reg  <= clock_edge_select_i ? {tx_buf[14:0], 1'b0} : tx_buf;
      if (clock_edge_select_i) sdo_q <= out_bit(tx_buf, word_width_select_i);
    end else if (sample_ev) begin
      shift_reg[IN_BIT] <= sdi_s;
      bit_cnt    <= complete ? 5'h00 : bit_cnt + 5'h01;
      slave_busy <= !complete;
    end else if (shift_ok) begin
      sdo_q      <= out_bit(shift_reg, word_width_select_i);
      shift_reg  <= {shift_reg[14:0], 1'b0};
      slave_busy <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit and receive buffers behind one port
  // ----------------------------------------------------------------
  // a new write wins over the load that empties the holding buffer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_buf    <= BUFFER_RESET;
      tx_full_o <= 1'b0;
    end else begin
      if (buf_write_i) tx_buf <= buf_wdata_i;
      if (buf_write_i) tx_full_o <= 1'b1;
      else if (load_go) tx_full_o <= 1'b0;
    end
  end

  // a read in the completion cycle frees room, so the word is kept
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_buf            <= BUFFER_RESET;
      rx_full_o         <= 1'b0;
      rx_overrun_flag_o <= 1'b0;
    end else begin
      if (complete && rx_room) begin
        rx_buf    <= rx_word;
        rx_full_o <= 1'b1;
      end else if (buf_read_i) begin
        rx_full_o <= 1'b0;
      end
      if (complete && !rx_room) rx_overrun_flag_o <= 1'b1;
      else if (buf_read_i) rx_overrun_flag_o <= 1'b0;
    end
  end

  // completion flag is sticky, set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_flag_o <= 1'b0;
    end else if (complete) begin
      irq_flag_o <= 1'b1;
    end else if (irq_clear_i) begin
      irq_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign buf_rdata_o          = rx_buf;
  assign irq_o                = irq_flag_o && irq_enable_i;
  assign serial_data_out_o    = sdo_q;
  assign serial_data_out_oe_o = port_enable_i &&
                                (master_mode_i || !slave_select_enable_i || !ss_n_s);
  assign shift_clock_pin_o    = master_mode_i ? sck_level : clock_idle_polarity_i;
  assign shift_clock_pin_oe_o = port_enable_i && master_mode_i;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_write_idle;
    port_enable_i && master_mode_i && buf_write_i && !tx_full_o && !busy && !rx_overrun_flag_o
      && !restart;
  endsequence

  sequence s_select_high;
    port_enable_i && slave_select_enable_i && !master_mode_i && slave_select_n_i;
  endsequence

  property p_sdo_from_msb;
    shift_ok && !restart && !load_go && !sample_ev
      |=> serial_data_out_o == $past(out_bit(shift_reg, word_width_select_i));
  endproperty
  a_sdo_from_msb: assert property (p_sdo_from_msb) else $error("data out not msb");

  property p_rx_copy;
    complete && !rx_full_o |=> rx_full_o && (buf_rdata_o == $past(rx_word));
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("word not copied");

  property p_overrun;
    complete && rx_full_o && !buf_read_i |=> rx_overrun_flag_o && $stable(buf_rdata_o);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_overrun_freeze;
    rx_overrun_flag_o && !buf_read_i && !restart |=> $stable(shift_reg) && $stable(bit_cnt);
  endproperty
  a_overrun_freeze: assert property (p_overrun_freeze) else $error("moved in overrun");

  property p_irq;
    complete |=> irq_flag_o ##0 (irq_o == irq_enable_i);
  endproperty
  a_irq: assert property (p_irq) else $error("completion flag missing");

  property p_master_start;
    s_write_idle ##1 (master_mode_i && port_enable_i && !restart) |=> state == CLK_RUN;
  endproperty
  a_master_start: assert property (p_master_start) else $error("master did not start");

  property p_ss_release;
    s_select_high [*3] |-> !serial_data_out_oe_o;
  endproperty
  a_ss_release: assert property (p_ss_release) else $error("data out driven");

  property p_ss_restart;
    ss_rise && port_enable_i |=> bit_cnt == 5'h00 && !slave_busy;
  endproperty
  a_ss_restart: assert property (p_ss_restart) else $error("no restart on select");

  property p_rx_read;
    buf_read_i && !complete |=> !rx_full_o && !rx_overrun_flag_o;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("read did not clear");

  // polarity may move between words; only a steady level is held to account
  property p_idle_level;
    state == CLK_IDLE && master_mode_i
      |=> $stable(clock_idle_polarity_i) |-> shift_clock_pin_o == clock_idle_polarity_i;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

endmodule
`default_nettype wire

// >>> test/link_peer.sv
/*
  Far-end model of the serial link: with edge select set it samples on the
  idle-to-active clock edge and changes data on the other, with it clear
  the reverse; it can also act as clock master.
  Assumes the bench resolves the clock and data pins before they arrive.
*/
`timescale 1ns/100ps
`default_nettype none
module link_peer (
  input  wire logic        clk_i,
  input  wire logic        pol_i,
  input  wire logic        cke_i,
  input  wire logic        sck_i,
  input  wire logic        sdo_i,
  output logic             sdi_o,
  output var  logic        sck_o,
  output var  logic        ss_n_o,
  output var  logic [15:0] rx_o
);
  // ----------------------------------------------------------------
  // shift partner
  // ----------------------------------------------------------------
  logic [15:0] tx     = 16'h0000;
  int          idx    = 0;
  int          n      = 8;
  initial sck_o  = 1'b0;
  initial ss_n_o = 1'b1;
  initial rx_o   = 16'h0000;
  assign sdi_o = tx[idx];

  // index wraps so back-to-back words need no reload
  always @(sck_i) begin
    if ((sck_i !== pol_i) == cke_i) rx_o <= {rx_o[14:0], sdo_i};
    else idx <= (idx == 0) ? n - 1 : idx - 1;
  end

  task automatic load(input logic [15:0] w, input int bits);
    tx  = w;
    n   = bits;
    // change-first mode steps onto the msb at the first edge
    idx = cke_i ? bits - 1 : 0;
  endtask

  // clock master role, select held low only when sel is set
  task automatic frame(input int pulses, input int h, input logic sel);
    @(negedge clk_i);
    ss_n_o <= ~sel;
    repeat (h) @(negedge clk_i);
    repeat (2 * pulses) begin
      sck_o <= ~sck_o;
      repeat (h) @(negedge clk_i);
    end
    ss_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> test/test_serial_peripheral_port.sv
/*
  Self-checking bench for the serial peripheral port: master runs with
  random widths, prescales and polarity, back-to-back and overrun, slave
  runs with select gating and abort. Assumes link_peer as the far end.
*/
`timescale 1ns/100ps
`default_nettype none
module test_serial_peripheral_port;
  import serial_port_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic clk_i = 0, reset_n_i = 0, en = 0, mst = 0, wide = 0, pol = 0, sse = 0;
  logic irq_en = 0, irq_clr = 0, wr = 0, rd = 0, sck_q = 0, cke = 1;
  logic [1:0]  pri = 2'h0;
  logic [2:0]  sec = 3'h0;
  logic [15:0] wdata = 16'h0000, rdata, prx, rnd = 16'hF2C5;
  logic        rx_full, tx_full, ovr, irq_flag, irq, sdo, sdo_oe, sck, sck_oe, sdi, psck, ss_n;
  int          err_count = 0, n_tests = 0, tog = 0, t_first = 0, t_last = 0, cyc = 0, h = 4;
  // undriven data line shows the inverse, never a held bit
  wire logic sck_w = sck_oe ? sck : psck;
  wire logic sdo_w = sdo_oe ? sdo : ~sdo;

  always #50 clk_i = ~clk_i;

  serial_peripheral_port dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .port_enable_i(en),
    .master_mode_i(mst), .word_width_select_i(wide), .clock_idle_polarity_i(pol),
    .clock_edge_select_i(cke), .slave_select_enable_i(sse), .primary_prescale_i(pri),
    .secondary_prescale_i(sec), .irq_enable_i(irq_en), .irq_clear_i(irq_clr),
    .buf_write_i(wr), .buf_wdata_i(wdata), .buf_read_i(rd), .buf_rdata_o(rdata),
    .rx_full_o(rx_full), .tx_full_o(tx_full), .rx_overrun_flag_o(ovr),
    .irq_flag_o(irq_flag), .irq_o(irq), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
    .serial_data_out_oe_o(sdo_oe), .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck),
    .shift_clock_pin_oe_o(sck_oe), .slave_select_n_i(ss_n));

  link_peer peer_u (.clk_i(clk_i), .pol_i(pol), .cke_i(cke), .sck_i(sck_w), .sdo_i(sdo_w),
    .sdi_o(sdi),
    .sck_o(psck), .ss_n_o(ss_n), .rx_o(prx));

  // toggle monitor on the settled falling edge
  always @(negedge clk_i) begin
    cyc = cyc + 1;
    if (sck_oe === 1'b1 && sck !== sck_q) begin
      if (tog == 0) t_first = cyc;
      t_last = cyc;
      tog = tog + 1;
    end
    sck_q = sck;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] trim(input logic [15:0] w);
    return wide ? w : {8'h00, w[7:0]};
  endfunction

  // wide enough for the flag-and-data groups compared at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_i) s = 1'b1;
    @(negedge clk_i) s = 1'b0;
  endtask

  task automatic write(input logic [15:0] w);
    wdata = w;
    pulse(wr);
  endtask

  // bounded wait for completion; a hang ends the run
  task automatic wait_irq;
    int i;
    for (i = 0; i < 6000 && irq_flag !== 1'b1; i++) @(negedge clk_i);
    if (i == 6000) begin
      err_count = err_count + 1;
      $display("[ERR] %0t completion never seen", $time);
      report_and_stop();
    end
  endtask

  // one master word, both directions checked
  task automatic m_xfer(input logic [15:0] w, input logic [15:0] pw);
    int bits;
    bits = wide ? 16 : 8;
    h = 4 * (pri + 1) * (sec + 1);
    peer_u.load(pw, bits);
    tog = 0;
    write(w);
    wait_irq();
    repeat (h + 2) @(negedge clk_i);
    check({rx_full, irq_flag, irq}, {2'b11, irq_en});
    check(rdata, trim(pw));
    check(trim(prx), trim(w));
    check(tog, 2 * bits);
    check(t_last - t_first, (2 * bits - 1) * h);
    check({sck, sck_oe}, {pol, 1'b1});
    pulse(rd);
    pulse(irq_clr);
    check({rx_full, irq_flag}, 2'b00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    check({rx_full, tx_full, ovr, irq_flag, irq, rdata}, 21'h00_0000);
    en = 1'b1;
    mst = 1'b1;
    // random master runs, slowest and fastest prescale first
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      {wide, pol, irq_en, pri, sec} = rnd[7:0];
      cke = rnd[8];
      if (k == 0) {wide, pri, sec} = 6'h3F;
      if (k == 1) {pri, sec} = 5'h00;
      repeat (4) @(negedge clk_i);
      m_xfer(lfsr(rnd), lfsr(lfsr(rnd)));
      $display("master run %0d done", k);
    end
    // back-to-back pair, second word lost to overrun, then frozen clock
    {wide, pol, pri, sec} = 7'h00;
    cke = 1'b1;
    repeat (4) @(negedge clk_i);
    peer_u.load(16'h00A5, 8);
    tog = 0;
    write(16'h003C);
    write(16'h00C3);
    check(tx_full, 1'b1);
    wait_irq();
    for (int i = 0; i < 200 && tog < 16; i++) @(negedge clk_i);
    check(tog, 16);
    peer_u.load(16'h005A, 8);
    pulse(irq_clr);
    wait_irq();
    repeat (8) @(negedge clk_i);
    check({ovr, rdata}, 17'h1_00A5);
    check(prx[15:0], 16'h3CC3);
    tog = 0;
    write(16'h0011);
    repeat (200) @(negedge clk_i);
    check(tog, 0);
    check(tx_full, 1'b1);
    // the frozen last half period ends after the read, so reload the peer only then
    pulse(rd);
    for (int i = 0; i < 50 && tog < 1; i++) @(negedge clk_i);
    check(tog, 1);
    peer_u.load(16'h0096, 8);
    pulse(irq_clr);
    wait_irq();
    check({ovr, rdata}, 17'h0_0096);
    pulse(rd);
    $display("overrun run done");
    // slave: unselected frame ignored, aborted frame, then a full word
    {mst, sse, wide, irq_en} = 4'b0111;
    pulse(irq_clr);
    write(16'hB00F);
    check(sdo_oe, 1'b0);
    peer_u.frame(16, 8, 1'b0);
    repeat (8) @(negedge clk_i);
    check({irq_flag, rx_full}, 2'b00);
    peer_u.frame(5, 8, 1'b1);
    peer_u.load(16'h6E21, 16);
    peer_u.frame(16, 8, 1'b1);
    wait_irq();
    // let the raised select pass the synchroniser before looking at the output enable
    repeat (4) @(negedge clk_i);
    check({irq, rx_full, sdo_oe}, 3'b110);
    check(rdata, 16'h6E21);
    check(prx, 16'hB00F);
    $display("slave run done");
    report_and_stop();
  end
endmodule
`default_nettype wire
